// [bench/swh_dev_model.sv]
// behavioural sensor on the shared line, the far side of the bus master
// assumes line_in is the resolved pulled-up line, sampled on clk_in at 10 MHz
`default_nettype none
module swh_dev_model #(
  parameter logic [63:0] ID_P = 64'h0
) (
  input  wire logic   clk_in,
  input  wire logic   line_in,
  input  wire logic   present_in,
  input  wire logic   alarm_in,
  output logic        drive_low_out,
  output logic [71:0] buf_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        prev_q = 1'b1;
  logic        func_q = 1'b0;
  logic        rst_q  = 1'b0;
  logic        slot_q = 1'b0;
  logic [7:0]  sh     = 8'h00;
  logic [7:0]  nb;
  logic [71:0] tx_q   = 72'h0;
  logic        tx_bit;
  int          low_n  = 0;
  int          t      = 0;
  int          pres_t = -1;
  int          mode   = 4;
  int          bitn   = 0;
  int          sub    = 0;

  initial drive_low_out = 1'b0;
  initial buf_out = 72'h21_FF_3F_00_00_5A_7D_01_91;
  assign nb = {line_in, sh[7:1]};
  assign tx_bit = (mode == 2) ? (ID_P[bitn] ^ (sub == 1)) : tx_q[bitn];

  // modes: 0 command, 1 send, 2 search, 3 buffer write, 4 quiet
  always @(posedge clk_in) begin
    prev_q <= line_in;
    low_n <= line_in ? 0 : low_n + 1;
    t <= slot_q ? t + 1 : 0;
    if (low_n == 800) begin
      rst_q <= 1'b1;
      mode <= 0;
      func_q <= 1'b0;
      bitn <= 0;
      sub <= 0;
      slot_q <= 1'b0;
      drive_low_out <= 1'b0;
    end else if (rst_q && line_in) begin
      rst_q <= 1'b0;
      pres_t <= 0;
    end else if (pres_t >= 0) begin
      pres_t <= (pres_t == 750) ? -1 : pres_t + 1;
      drive_low_out <= present_in && pres_t >= 150 && pres_t < 750;
    end else if (prev_q && !line_in) begin
      slot_q <= 1'b1;
      drive_low_out <= (mode == 1 || (mode == 2 && sub < 2)) && !tx_bit;
    end else if (slot_q && t == 300) begin
      slot_q <= 1'b0;
      drive_low_out <= 1'b0;
      sh <= nb;
      bitn <= bitn + 1;
      case (mode)
        0: if (bitn == 7) begin
          bitn <= 0;
          mode <= 4;
          if (!func_q) begin
            if (nb == 8'h33) begin
              mode <= 1;
              tx_q <= {8'h00, ID_P};
            end
            if (nb == 8'hF0 || (nb == 8'hEC && alarm_in)) mode <= 2;
            if (nb == 8'hCC) begin
              mode <= 0;
              func_q <= 1'b1;
            end
          end else begin
            if (nb == 8'hBE) begin
              mode <= 1;
              tx_q <= buf_out;
            end
            if (nb == 8'h4E) begin
              mode <= 3;
              bitn <= 16;
            end
          end
        end
        1: if (bitn == 71) mode <= 4;
        2: if (sub == 2) begin
          sub <= 0;
          if (line_in != ID_P[bitn] || bitn == 63) mode <= 4;
        end else begin
          sub <= sub + 1;
          bitn <= bitn;
        end
        3: if (bitn % 8 == 7) begin
          buf_out[bitn-7 +: 8] <= nb;
          if (bitn == 39) mode <= 4;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the single-wire bus master with a sensor model
// assumes the master and the model share one pulled-up line resolved here
`default_nettype none
module tb_top;
  import swh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] DEV_ID = 64'h9E00_6B3A_4C21_7D13; // arbitrary identifier
  localparam int          CONV_P = 100;
  logic        clk_in    = 1'b0;
  logic        rst_n_in  = 1'b0;
  logic        cmd_valid = 1'b0;
  swh_op_t     cmd_op    = SWH_OP_RESET;
  logic [7:0]  cmd_data  = 8'h00;
  logic        cmd_dir   = 1'b0;
  logic        present   = 1'b1;
  logic        alarm     = 1'b0;
  logic        op_err;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          n;
  wire logic   cmd_ready_out, done_out, err_out, fault_out, presence_out;
  wire logic   dq_out, dq_oe_out, dev_low, dq_line;
  wire logic [7:0]  rd_data_out, crc_out;
  wire logic [2:0]  trip_out;
  wire logic [71:0] dev_buf;

  assign dq_line = (dq_oe_out ? dq_out : 1'b1) & ~dev_low;

  swh_master #(.PWRUP_CYC_P(50), .RST_LOW_CYC_P(1000), .RST_WAIT_CYC_P(800), .CONV_CYC_P(CONV_P)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
    .cmd_data_in(cmd_data), .cmd_dir_in(cmd_dir), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
    .err_out(err_out), .fault_out(fault_out), .presence_out(presence_out), .rd_data_out(rd_data_out),
    .trip_out(trip_out), .crc_out(crc_out), .dq_in(dq_line), .dq_out(dq_out), .dq_oe_out(dq_oe_out));

  swh_dev_model #(.ID_P(DEV_ID)) i_dev (.clk_in(clk_in), .line_in(dq_line), .present_in(present),
    .alarm_in(alarm), .drive_low_out(dev_low), .buf_out(dev_buf));

  initial forever #50 clk_in = ~clk_in;

  task automatic print_verdict;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      bad_count++;
      print_verdict;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction

  // one request held until taken, then wait for its answer
  task automatic bus_op(input swh_op_t o, input logic [7:0] d, output logic e);
    logic seen;
    seen = 1'b0;
    e = 1'b1;
    cmd_op <= o;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge clk_in);
    while (cmd_ready_out !== 1'b1) @(posedge clk_in);
    cmd_valid <= 1'b0;
    for (int k = 0; k < 30000 && !seen; k++) begin
      @(posedge clk_in);
      if (done_out === 1'b1 || err_out === 1'b1) begin
        seen = 1'b1;
        e = err_out;
      end
    end
    chk("answered", 8'h01, {7'h00, seen});
  endtask

  task automatic bus_rst(input logic exp_pres);
    bus_op(SWH_OP_RESET, 8'h00, op_err);
    chk("reset_err", 8'h00, {7'h00, op_err});
    chk("presence", {7'h00, exp_pres}, {7'h00, presence_out});
  endtask

  task automatic wr(input logic [7:0] d, input logic exp_err);
    bus_op(SWH_OP_WRITE, d, op_err);
    chk("write_err", {7'h00, exp_err}, {7'h00, op_err});
  endtask

  task automatic t_order;
    wr(CMD_READID, 1'b1);
    present <= 1'b0;
    bus_rst(1'b0);
    present <= 1'b1;
    bus_rst(1'b1);
    bus_op(SWH_OP_READ, 8'h00, op_err);
    chk("read_refused", 8'h01, {7'h00, op_err});
  endtask

  task automatic t_readid;
    bus_rst(1'b1);
    wr(CMD_READID, 1'b0);
    bus_op(SWH_OP_READ, 8'h00, op_err);
    chk("id_byte", DEV_ID[7:0], rd_data_out);
    chk("id_crc", crc8(DEV_ID[7:0]), crc_out);
  endtask

  task automatic t_search;
    bus_rst(1'b1);
    wr(CMD_SEARCH, 1'b0);
    cmd_dir <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus_op(SWH_OP_TRIPLET, 8'h00, op_err);
      chk("trip", {5'h00, DEV_ID[i], ~DEV_ID[i], DEV_ID[i]}, {5'h00, trip_out});
    end
    bus_rst(1'b1);
    wr(CMD_ASEARCH, 1'b0);
    bus_op(SWH_OP_TRIPLET, 8'h00, op_err);
    chk("fault_err", 8'h01, {7'h00, op_err});
    chk("fault_flag", 8'h01, {7'h00, fault_out});
    chk("fault_trip", 8'h03, {5'h00, trip_out});
  endtask

  task automatic t_skip;
    bus_rst(1'b1);
    wr(CMD_SKIP, 1'b0);
    wr(CMD_RDBUF, 1'b1);
    wr(CMD_CONVERT, 1'b0);
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 1000) begin
      @(posedge clk_in);
      n++;
    end
    chk("conv_wait", 8'h01, {7'h00, n >= CONV_P - 1 && n <= CONV_P + 2});
    wr(CMD_RDBUF, 1'b1);
  endtask

  task automatic t_wrbuf;
    bus_rst(1'b1);
    wr(CMD_SKIP, 1'b0);
    wr(CMD_WRBUF, 1'b0);
    wr(8'hA5, 1'b0);
    chk("wr_shift", 8'h00, rd_data_out);
    wr(8'h3C, 1'b0);
    bus_rst(1'b1);
    chk("buf_byte3", 8'hA5, dev_buf[23:16]);
    chk("buf_byte4", 8'h3C, dev_buf[31:24]);
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 1000) begin
      @(posedge clk_in);
      n++;
    end
    chk("powerup_wait", 8'h01, {7'h00, n >= 50 && n < 1000});
    t_order;
    t_readid;
    t_search;
    t_skip;
    t_wrbuf;
    print_verdict;
  end
endmodule
`default_nettype wire

// [rtl/swh_master.sv]
// bus master for a single-wire open-drain temperature sensor bus
// assumes pin pulled up externally; dq_in is asynchronous to clk_in
// Function
// R1 - reset pulse holds line low 480us
// R2 - presence sampled low at 70us
// R3 - master starts all slots from falling edge
// R4 - slot at least 65us, recovery 1us
// R5 - read slot opened by low pulse
// R6 - device drives zero 15 to 60us
// R7 - release at 5us, sample at 15us
// R8 - write slot opened by low pulse
// R9 - write zero holds low 60us
// R10 - write one releases within 15us
// R11 - no traffic for 3ms after power-up
// R12 - reset, addressing, function, in order
// R13 - search: bit, complement, chosen bit
// R14 - decode search pair, both ones fault
// R15 - alarm search runs like search
// R16 - read identifier streams 64 bits
// R17 - match sends 64-bit identifier
// R18 - no buffer read after skip
// R19 - wait for conversion before traffic
// R20 - buffer read nine bytes, reset ends
// R21 - buffer write bytes 3 to 5
// R22 - everything least significant bit first
// R23 - CRC x8+x5+x4+1, init zero
// R24 - presence covers master sampling point
// R25 - device samples write slot midway
`default_nettype none
module swh_master #(
  parameter int PWRUP_CYC_P    = swh_pkg::PWRUP_CYC,
  parameter int RST_LOW_CYC_P  = swh_pkg::RST_LOW_CYC,
  parameter int RST_WAIT_CYC_P = swh_pkg::RST_WAIT_CYC,
  parameter int CONV_CYC_P     = swh_pkg::CONV_CYC
) (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic            cmd_valid_in,
  input  wire swh_pkg::swh_op_t cmd_op_in,
  input  wire logic [7:0]      cmd_data_in,
  input  wire logic            cmd_dir_in,
  output logic                 cmd_ready_out,
  output logic                 done_out,
  output logic                 err_out,
  output logic                 fault_out,
  output logic                 presence_out,
  output logic [7:0]           rd_data_out,
  output logic [2:0]           trip_out,
  output logic [7:0]           crc_out,
  input  wire logic            dq_in,
  output logic                 dq_out,
  output logic                 dq_oe_out
);
  import swh_pkg::*;

  localparam logic [CW-1:0] C_PWRUP   = CW'(PWRUP_CYC_P - 1);
  localparam logic [CW-1:0] C_RSTLOW  = CW'(RST_LOW_CYC_P - 1);
  localparam logic [CW-1:0] C_RSTWAIT = CW'(RST_WAIT_CYC_P - 1);
  localparam logic [CW-1:0] C_CONV    = CW'(CONV_CYC_P - 1);
  localparam logic [CW-1:0] C_PRES    = CW'(PRES_SMP_CYC);
  localparam logic [CW-1:0] C_SLOT    = CW'(SLOT_CYC - 1);
  localparam logic [CW-1:0] C_REC     = CW'(REC_CYC - 1);
  localparam logic [CW-1:0] C_RDLOW   = CW'(RD_LOW_CYC);
  localparam logic [CW-1:0] C_RDSMP   = CW'(RD_SMP_CYC);
  localparam logic [CW-1:0] C_W0LOW   = CW'(W0_LOW_CYC);
  localparam logic [CW-1:0] C_W1LOW   = CW'(W1_LOW_CYC);

  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    crc_step = (crc >> 1) ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  swh_state_t state_reg, state_next;
  swh_phase_t phase_reg, phase_next;
  swh_op_t    op_reg, op_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next, crc_reg, crc_next, rd_reg, rd_next;
  logic [2:0] bit_reg, bit_next, acnt_reg, acnt_next, trip_reg, trip_next;
  logic [1:0] step_reg, step_next, pair_reg, pair_next;
  logic       wr_reg, wr_next, sbit_reg, sbit_next, samp_reg, samp_next;
  logic       dir_reg, dir_next, skip_reg, skip_next, conv_reg, conv_next;
  logic       pres_reg, pres_next, done_reg, done_next, err_reg, err_next;
  logic       fault_reg, fault_next, oe_reg, oe_next;
  logic       dq_meta_reg, dq_sync_reg;
  logic       accept, legal;
  logic [CW-1:0] low_len;
  logic [15:0] low_run_reg;

  assign cmd_ready_out = (state_reg == SWH_ST_IDLE);
  assign accept        = cmd_valid_in && cmd_ready_out;
  assign done_out      = done_reg;
  assign err_out       = err_reg;
  assign fault_out     = fault_reg;
  assign presence_out  = pres_reg;
  assign rd_data_out   = rd_reg;
  assign trip_out      = trip_reg;
  assign crc_out       = crc_reg;
  assign dq_out        = 1'b0;
  assign dq_oe_out     = oe_reg;
  assign low_len       = wr_reg ? (sbit_reg ? C_W1LOW : C_W0LOW) : C_RDLOW; // R9 R10

  // legality of a request against the transaction order
  always_comb begin
    legal = 1'b0;
    unique case (phase_reg)
      SWH_PH_NONE:   legal = (cmd_op_in == SWH_OP_RESET); // R12
      SWH_PH_ADDR:   legal = (cmd_op_in == SWH_OP_RESET) || ((cmd_op_in == SWH_OP_WRITE) && // R12
                             (cmd_data_in == CMD_SEARCH || cmd_data_in == CMD_ASEARCH ||
                              cmd_data_in == CMD_READID || cmd_data_in == CMD_MATCH || cmd_data_in == CMD_SKIP));
      SWH_PH_SEARCH: legal = (cmd_op_in == SWH_OP_RESET) || (cmd_op_in == SWH_OP_TRIPLET); // R13
      SWH_PH_FUNC:   legal = (cmd_op_in == SWH_OP_RESET) || ((cmd_op_in == SWH_OP_WRITE) &&
                             (cmd_data_in == CMD_CONVERT || cmd_data_in == CMD_WRBUF ||
                              (cmd_data_in == CMD_RDBUF && !skip_reg))); // R18
      default:       legal = (cmd_op_in != SWH_OP_TRIPLET);
    endcase
  end

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    op_next    = op_reg;
    cnt_next   = cnt_reg + 1'b1;
    shift_next = shift_reg;
    crc_next   = crc_reg;
    rd_next    = rd_reg;
    bit_next   = bit_reg;
    acnt_next  = acnt_reg;
    trip_next  = trip_reg;
    step_next  = step_reg;
    pair_next  = pair_reg;
    wr_next    = wr_reg;
    sbit_next  = sbit_reg;
    samp_next  = samp_reg;
    dir_next   = dir_reg;
    skip_next  = skip_reg;
    conv_next  = conv_reg;
    pres_next  = pres_reg;
    done_next  = 1'b0;
    err_next   = 1'b0;
    fault_next = fault_reg;
    oe_next    = 1'b0;
    unique case (state_reg)
      SWH_ST_POWER: begin
        if (cnt_reg == C_PWRUP) begin // R11
          state_next = SWH_ST_IDLE;
        end
      end
      SWH_ST_IDLE: begin
        cnt_next = '0;
        if (accept && !legal) begin
          err_next = 1'b1;
        end else if (accept) begin
          op_next    = cmd_op_in;
          shift_next = cmd_data_in;
          dir_next   = cmd_dir_in;
          bit_next   = 3'h0;
          step_next  = 2'h0;
          fault_next = 1'b0;
          wr_next    = (cmd_op_in == SWH_OP_WRITE);
          sbit_next  = cmd_data_in[0]; // R22
          state_next = SWH_ST_SLOT; // R3
          unique case (cmd_op_in)
            SWH_OP_RESET: begin
              state_next = SWH_ST_RST_LOW; // R1
              phase_next = SWH_PH_ADDR;
              skip_next  = 1'b0;
              crc_next   = CRC_INIT;
            end
            SWH_OP_WRITE: begin
              if (phase_reg == SWH_PH_ADDR) begin
                acnt_next  = 3'h0;
                crc_next   = CRC_INIT;
                skip_next  = (cmd_data_in == CMD_SKIP);
                phase_next = (cmd_data_in == CMD_SKIP) ? SWH_PH_FUNC : // R18
                             (cmd_data_in == CMD_SEARCH || cmd_data_in == CMD_ASEARCH) ? SWH_PH_SEARCH : // R15
                             SWH_PH_ADATA; // R16 R17
              end else if (phase_reg == SWH_PH_FUNC) begin
                crc_next   = CRC_INIT; // R20
                conv_next  = (cmd_data_in == CMD_CONVERT);
                phase_next = (cmd_data_in == CMD_CONVERT) ? SWH_PH_NONE : SWH_PH_FDATA; // R19 R21
              end
            end
            SWH_OP_TRIPLET: begin
              wr_next = 1'b0;
            end
            default: begin
              wr_next = 1'b0;
            end
          endcase
          if ((cmd_op_in != SWH_OP_RESET) && (phase_reg == SWH_PH_ADATA)) begin
            acnt_next = acnt_reg + 3'h1; // R16 R17
            if (acnt_reg == ID_BYTES_M1) begin
              phase_next = SWH_PH_FUNC;
            end
          end
        end
      end
      SWH_ST_RST_LOW: begin
        oe_next = 1'b1; // R1
        if (cnt_reg == C_RSTLOW) begin
          state_next = SWH_ST_RST_WAIT;
          cnt_next   = '0;
        end
      end
      SWH_ST_RST_WAIT: begin
        if (cnt_reg == C_PRES) begin
          pres_next = !dq_sync_reg; // R2 R24
        end
        if (cnt_reg == C_RSTWAIT) begin
          state_next = SWH_ST_IDLE;
          done_next  = 1'b1;
        end
      end
      SWH_ST_SLOT: begin
        oe_next = (cnt_reg < low_len); // R5 R7 R8 R9 R10
        if (!wr_reg && cnt_reg == C_RDSMP) begin
          samp_next = dq_sync_reg; // R6 R7
        end
        if (cnt_reg == C_SLOT) begin
          state_next = SWH_ST_RECOV; // R4
          cnt_next   = '0;
        end
      end
      SWH_ST_RECOV: begin
        if (cnt_reg == C_REC) begin // R4
          state_next = SWH_ST_SLOT;
          cnt_next   = '0;
          if (op_reg == SWH_OP_TRIPLET) begin
            step_next = step_reg + 2'h1;
            if (step_reg == 2'h0) begin
              pair_next[0] = samp_reg; // R13
            end else if (step_reg == 2'h1) begin
              pair_next[1] = samp_reg;
              wr_next      = 1'b1;
              unique case ({samp_reg, pair_reg[0]}) // R14
                2'b00:   sbit_next = dir_reg;
                2'b10:   sbit_next = 1'b0;
                2'b01:   sbit_next = 1'b1;
                default: sbit_next = 1'b0;
              endcase
              if (samp_reg && pair_reg[0]) begin
                fault_next = 1'b1; // R14
                err_next   = 1'b1;
                done_next  = 1'b1;
                trip_next  = {1'b0, samp_reg, pair_reg[0]};
                state_next = SWH_ST_IDLE;
              end
            end else begin
              trip_next  = {sbit_reg, pair_reg[1], pair_reg[0]}; // R13
              done_next  = 1'b1;
              state_next = SWH_ST_IDLE;
            end
          end else begin
            bit_next = bit_reg + 3'h1;
            if (wr_reg) begin
              shift_next = {1'b0, shift_reg[7:1]}; // R22
            end else begin
              shift_next = {samp_reg, shift_reg[7:1]}; // R22
              crc_next   = crc_step(crc_reg, samp_reg); // R23
            end
            sbit_next = shift_next[0];
            if (bit_reg == 3'h7) begin
              rd_next    = shift_next;
              done_next  = 1'b1;
              state_next = conv_reg ? SWH_ST_CONV : SWH_ST_IDLE; // R19
            end
          end
        end
      end
      SWH_ST_CONV: begin
        conv_next = 1'b0;
        if (cnt_reg == C_CONV) begin // R19
          state_next = SWH_ST_IDLE;
        end
      end
      default: begin
        state_next = SWH_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    dq_meta_reg <= dq_in;
    dq_sync_reg <= dq_meta_reg;
    if (!rst_n_in) begin
      state_reg <= SWH_ST_POWER;
      phase_reg <= SWH_PH_NONE;
      op_reg    <= SWH_OP_RESET;
      cnt_reg   <= '0;
      shift_reg <= 8'h00;
      crc_reg   <= CRC_INIT;
      rd_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      acnt_reg  <= 3'h0;
      trip_reg  <= 3'h0;
      step_reg  <= 2'h0;
      pair_reg  <= 2'h0;
      wr_reg    <= 1'b0;
      sbit_reg  <= 1'b0;
      samp_reg  <= 1'b0;
      dir_reg   <= 1'b0;
      skip_reg  <= 1'b0;
      conv_reg  <= 1'b0;
      pres_reg  <= 1'b0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      fault_reg <= 1'b0;
      oe_reg    <= 1'b0;
      low_run_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      op_reg    <= op_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      crc_reg   <= crc_next;
      rd_reg    <= rd_next;
      bit_reg   <= bit_next;
      acnt_reg  <= acnt_next;
      trip_reg  <= trip_next;
      step_reg  <= step_next;
      pair_reg  <= pair_next;
      wr_reg    <= wr_next;
      sbit_reg  <= sbit_next;
      samp_reg  <= samp_next;
      dir_reg   <= dir_next;
      skip_reg  <= skip_next;
      conv_reg  <= conv_next;
      pres_reg  <= pres_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
      fault_reg <= fault_next;
      oe_reg    <= oe_next;
      low_run_reg <= oe_reg ? low_run_reg + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_RST_LEN: assert property (($past(dq_oe_out) && !dq_oe_out && state_reg == SWH_ST_RST_WAIT) // R1
    |-> low_run_reg == 16'(RST_LOW_CYC_P)) else $error("reset pulse length wrong");
  AST_PRES: assert property ((state_reg == SWH_ST_RST_WAIT && cnt_reg == C_PRES) // R2
    |=> presence_out == !$past(dq_sync_reg)) else $error("presence not sampled at 70us");
  AST_SLOT_LEN: assert property ($rose(state_reg == SWH_ST_RECOV) // R4
    |-> $past(cnt_reg) == C_SLOT) else $error("slot shorter than minimum");
  AST_RECOVERY: assert property ((state_reg == SWH_ST_SLOT && cnt_reg == '0) // R4
    |-> !dq_oe_out && !$past(dq_oe_out)) else $error("no released recovery before slot");
  AST_READ_LOW: assert property ((state_reg == SWH_ST_SLOT && !wr_reg && cnt_reg == C_RDLOW + 1'b1) // R7
    |-> !dq_oe_out && $past(dq_oe_out)) else $error("read slot release time wrong");
  AST_W0_LOW: assert property ((state_reg == SWH_ST_SLOT && wr_reg && !sbit_reg && cnt_reg == C_W0LOW) // R9
    |-> dq_oe_out ##1 !dq_oe_out) else $error("write zero low time wrong");
  AST_W1_LOW: assert property ((state_reg == SWH_ST_SLOT && wr_reg && sbit_reg && cnt_reg == C_W1LOW + 1'b1) // R10
    |-> !dq_oe_out && $past(dq_oe_out)) else $error("write one not released in time");
  AST_POWER: assert property ((state_reg == SWH_ST_POWER) // R11
    |-> !cmd_ready_out && !dq_oe_out) else $error("bus used during power-up wait");
  AST_ORDER: assert property ((accept && phase_reg == SWH_PH_NONE && cmd_op_in != SWH_OP_RESET) // R12
    |=> err_out && state_reg == SWH_ST_IDLE) else $error("out of order request accepted");
  AST_SKIP_BE: assert property ((accept && phase_reg == SWH_PH_FUNC && skip_reg && cmd_op_in == SWH_OP_WRITE
    && cmd_data_in == CMD_RDBUF) |=> err_out && !dq_oe_out) else $error("buffer read after skip sent"); // R18
  AST_CONV: assert property ($rose(state_reg == SWH_ST_CONV) // R19
    |-> (!cmd_ready_out && !dq_oe_out) [*8]) else $error("traffic during conversion");
  AST_FAULT: assert property ((state_reg == SWH_ST_RECOV && cnt_reg == C_REC && op_reg == SWH_OP_TRIPLET
    && step_reg == 2'h1 && samp_reg && pair_reg[0]) |=> fault_out && err_out && cmd_ready_out)
    else $error("search fault not reported"); // R14
endmodule
`default_nettype wire

// [rtl/swh_pkg.sv]
// constants and types for the single-wire sensor bus master
// assumes a 10 MHz system clock; all bus times are derived from it
`default_nettype none
package swh_pkg;
  localparam int CLK_MHZ = 10;
  localparam int CW      = 24;
  // bus times in microseconds
  localparam int PWRUP_US      = 3000;
  localparam int RST_LOW_US    = 480;
  localparam int RST_WAIT_US   = 480;
  localparam int PRES_SMP_US   = 70;
  localparam int SLOT_US       = 65;
  localparam int REC_US        = 1;
  localparam int RD_LOW_US     = 5;
  localparam int RD_SMP_US     = 15;
  localparam int W0_LOW_US     = 60;
  localparam int W1_LOW_US     = 5;
  localparam int CONV_US       = 750000;
  // cycle counts at the clock rate
  localparam int PWRUP_CYC     = PWRUP_US * CLK_MHZ;
  localparam int RST_LOW_CYC   = RST_LOW_US * CLK_MHZ;
  localparam int RST_WAIT_CYC  = RST_WAIT_US * CLK_MHZ;
  localparam int PRES_SMP_CYC  = PRES_SMP_US * CLK_MHZ;
  localparam int SLOT_CYC      = SLOT_US * CLK_MHZ;
  localparam int REC_CYC       = REC_US * CLK_MHZ;
  localparam int RD_LOW_CYC    = RD_LOW_US * CLK_MHZ;
  localparam int RD_SMP_CYC    = RD_SMP_US * CLK_MHZ;
  localparam int W0_LOW_CYC    = W0_LOW_US * CLK_MHZ;
  localparam int W1_LOW_CYC    = W1_LOW_US * CLK_MHZ;
  localparam int CONV_CYC      = CONV_US * CLK_MHZ;
  // command codes, CRC constants and identifier byte count
  localparam logic [7:0] CMD_SEARCH  = 8'hF0;
  localparam logic [7:0] CMD_ASEARCH = 8'hEC;
  localparam logic [7:0] CMD_READID  = 8'h33;
  localparam logic [7:0] CMD_MATCH   = 8'h55;
  localparam logic [7:0] CMD_SKIP    = 8'hCC;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_RDBUF   = 8'hBE;
  localparam logic [7:0] CMD_WRBUF   = 8'h4E;
  localparam logic [7:0] CRC_POLY    = 8'h8C;
  localparam logic [7:0] CRC_INIT    = 8'h00;
  localparam logic [2:0] ID_BYTES_M1 = 3'h7;

  typedef enum logic [1:0] {
    SWH_OP_RESET   = 2'h0,
    SWH_OP_WRITE   = 2'h1,
    SWH_OP_READ    = 2'h2,
    SWH_OP_TRIPLET = 2'h3
  } swh_op_t;

  typedef enum logic [2:0] {
    SWH_ST_POWER    = 3'h0,
    SWH_ST_IDLE     = 3'h1,
    SWH_ST_RST_LOW  = 3'h2,
    SWH_ST_RST_WAIT = 3'h3,
    SWH_ST_SLOT     = 3'h4,
    SWH_ST_RECOV    = 3'h5,
    SWH_ST_CONV     = 3'h6
  } swh_state_t;

  typedef enum logic [2:0] {
    SWH_PH_NONE   = 3'h0,
    SWH_PH_ADDR   = 3'h1,
    SWH_PH_ADATA  = 3'h2,
    SWH_PH_SEARCH = 3'h3,
    SWH_PH_FUNC   = 3'h4,
    SWH_PH_FDATA  = 3'h5
  } swh_phase_t;
endpackage
`default_nettype wire
